// ---- src/tcd_decoder.sv ----
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module tcd_decoder
    import tcd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic control_station,
    input wire logic [7:0] modem_status,
    output logic [7:0] modem_control,
    output logic startup_req,
    output logic maint_req,
    output logic [tcd_pkg::SLOT_W-1:0] req_slot,
    output logic [7:0] req_trib,
    input wire logic startup_done,
    input wire logic [tcd_pkg::SLOT_W-1:0] done_slot,
    output logic return_bufs,
    output logic return_pool,
    output logic [tcd_pkg::NSLOT-1:0] poll_enable,
    output logic [tcd_pkg::NSLOT-1:0] answer_enable,
    output logic [tcd_pkg::NSLOT-1:0] maint_enable,
    output logic [tcd_pkg::NSLOT-1:0] pool_enable
);
    import tcd_pkg::*;

    logic [KEY_W-1:0] key_q;
    logic [7:0] trib_q;
    logic [7:0] param_q;
    logic [7:0] flag_q;
    logic [7:0] modem_q;
    logic [31:0] prdata_q;
    logic err_q;
    tcd_cmd_t cmd_q;
    logic resp_q;
    logic [1:0] kind_q;
    logic [7:0] code_q;
    logic [7:0] rtrib_q;
    logic [15:0] rparam_q;
    logic [SLOT_W-1:0] view_q;
    logic startup_q, maint_q, retb_q, retp_q;
    logic [SLOT_W-1:0] rslot_q;
    logic [7:0] rtrib_out_q;

    logic [NSLOT-1:0] valid_q;
    logic [7:0] addr_q [NSLOT];
    tcd_trib_t state_q [NSLOT];
    logic [NSLOT-1:0] pool_q;
    logic [NSLOT-1:0] platch_q;
    logic [1:0] pstate_q [NSLOT];

    logic [8*NSLOT-1:0] addr_flat;
    logic hit, free;
    logic [SLOT_W-1:0] hit_idx, free_idx;
    logic [7:0] modem_in;
    logic ctrl_stn;

    logic setup, wr_acc, rd_setup, mapped;
    logic cmd_go, exec;
    logic pool_busy;
    logic [1:0] ctrl_bits;

    // Station role and modem lines arrive from pins
    tcd_sync3 #(.W(9)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({control_station, modem_status}),
        .dout({ctrl_stn, modem_in})
    );

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : g_slot
            logic live;
            assign addr_flat[8*g +: 8] = addr_q[g];
            assign live = valid_q[g] && (state_q[g] != TS_HALT) && (pstate_q[g] == 2'h0);
            assign poll_enable[g] = live && ctrl_stn;
            assign answer_enable[g] = live && !ctrl_stn;
            assign maint_enable[g] = valid_q[g] && (state_q[g] == TS_MAINT);
            assign pool_enable[g] = valid_q[g] && pool_q[g];
        end
    endgenerate

    tcd_slot_match u_match (
        .valid(valid_q),
        .addrs(addr_flat),
        .key(trib_q),
        .hit(hit),
        .hit_idx(hit_idx),
        .free(free),
        .free_idx(free_idx)
    );

    // APB slave, zero wait states
    assign setup = psel && !penable;
    assign rd_setup = setup && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    always_comb begin
        case (paddr)
            A_CMD, A_TRIB, A_PARAM, A_FLAG, A_STAT, A_RESP, A_MODEM, A_SLOT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready = 1'b1;
    assign prdata = prdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= !mapped;
        end
    end
    assign pslverr = psel && penable && err_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                A_CMD: prdata_q <= {27'h0, key_q};
                A_TRIB: prdata_q <= {24'h0, trib_q};
                A_PARAM: prdata_q <= {24'h0, param_q};
                A_FLAG: prdata_q <= {24'h0, flag_q};
                A_STAT: prdata_q <= {8'h0, rtrib_q, code_q, 4'h0, kind_q,
                    cmd_q == CS_EXEC, resp_q};
                A_RESP: prdata_q <= {16'h0, rparam_q};
                A_MODEM: prdata_q <= {24'h0, modem_q};
                A_SLOT: prdata_q <= {13'h0, view_q, pstate_q[view_q], platch_q[view_q],
                    pool_q[view_q], state_q[view_q], valid_q[view_q], addr_q[view_q]};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Command fields hold still while a command executes
    assign cmd_go = wr_acc && (paddr == A_CMD) && (cmd_q == CS_IDLE);
    always_ff @(posedge clk) begin
        if (rst) begin
            key_q <= K_NOP;
            trib_q <= 8'h00;
            param_q <= 8'h00;
            flag_q <= 8'h00;
            view_q <= '0;
        end else if (wr_acc && cmd_q == CS_IDLE) begin
            case (paddr)
                A_CMD: key_q <= pwdata[KEY_W-1:0];
                A_TRIB: trib_q <= pwdata[7:0];
                A_PARAM: param_q <= pwdata[7:0];
                A_FLAG: flag_q <= pwdata[7:0];
                A_SLOT: view_q <= (pwdata < 32'(NSLOT)) ?
                    pwdata[SLOT_W-1:0] : '0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_q <= CS_IDLE;
        end else begin
            case (cmd_q)
                CS_IDLE: if (cmd_go) cmd_q <= CS_EXEC;
                CS_EXEC: cmd_q <= CS_IDLE;
                default: cmd_q <= CS_IDLE;
            endcase
        end
    end
    assign exec = (cmd_q == CS_EXEC);
    assign pool_busy = |(valid_q & pool_q);
    // Pool bits apply only when exactly one of the pair is set
    assign ctrl_bits = {flag_q[F_POOL_EN], flag_q[F_POOL_DIS]};

    // Slot table: creation, deletion and state moves
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_q <= '0;
            for (int i = 0; i < NSLOT; i++) begin
                addr_q[i] <= 8'h00;
                state_q[i] <= TS_HALT;
            end
        end else begin
            // A command writing the same slot's state in the same cycle overrides link completion
            if (startup_done && valid_q[done_slot] && state_q[done_slot] == TS_START) begin
                state_q[done_slot] <= TS_RUN;
            end
            if (exec) begin
                case (key_q)
                    K_ESTAB: begin
                        if (hit) begin
                            state_q[hit_idx] <= TS_HALT;
                        end else if (free && trib_q != 8'h00) begin
                            valid_q[free_idx] <= 1'b1;
                            addr_q[free_idx] <= trib_q;
                            state_q[free_idx] <= TS_HALT;
                        end
                    end
                    K_DELETE: if (hit) valid_q[hit_idx] <= 1'b0;
                    K_START: if (hit && state_q[hit_idx] == TS_HALT) begin
                        state_q[hit_idx] <= TS_START;
                    end
                    K_MAINT: if (hit && state_q[hit_idx] == TS_HALT) begin
                        state_q[hit_idx] <= TS_MAINT;
                    end
                    K_HALT: if (hit) state_q[hit_idx] <= TS_HALT;
                    default: ;
                endcase
            end
        end
    end

    // Flag byte effects on pool access and polling level
    always_ff @(posedge clk) begin
        if (rst) begin
            pool_q <= '0;
            platch_q <= '0;
            for (int i = 0; i < NSLOT; i++) begin
                pstate_q[i] <= 2'h0;
            end
        end else if (exec && hit) begin
            if (key_q == K_ESTAB) begin
                pool_q[hit_idx] <= 1'b0;
                platch_q[hit_idx] <= 1'b0;
                pstate_q[hit_idx] <= 2'h0;
            end
            // Rejected start-up or maintenance leaves the flags untouched
            if (key_q == K_NOP || key_q == K_ESTAB || ((key_q == K_START
                || key_q == K_MAINT) && state_q[hit_idx] == TS_HALT)) begin
                if (ctrl_bits == 2'b10) pool_q[hit_idx] <= 1'b1;
                if (ctrl_bits == 2'b01) pool_q[hit_idx] <= 1'b0;
                if (flag_q[F_POLL_LAT]) begin
                    platch_q[hit_idx] <= 1'b1;
                    pstate_q[hit_idx] <= param_q[1:0];
                end else if (flag_q[F_POLL_UNL]) begin
                    platch_q[hit_idx] <= 1'b0;
                    pstate_q[hit_idx] <= 2'h0;
                end
            end
            if (key_q == K_DELETE) begin
                // A slot reused later must not inherit a stale polling level
                pool_q[hit_idx] <= 1'b0;
                platch_q[hit_idx] <= 1'b0;
                pstate_q[hit_idx] <= 2'h0;
            end
        end
    end

    // Modem control register
    always_ff @(posedge clk) begin
        if (rst) begin
            modem_q <= MODEM_RST;
        end else if (exec && key_q == K_MDM_WR) begin
            modem_q <= param_q;
        end
    end
    assign modem_control = modem_q;

    // Link requests, one-cycle pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            startup_q <= 1'b0;
            maint_q <= 1'b0;
            retb_q <= 1'b0;
            retp_q <= 1'b0;
            rslot_q <= '0;
            rtrib_out_q <= 8'h00;
        end else begin
            startup_q <= exec && key_q == K_START && hit && state_q[hit_idx] == TS_HALT;
            maint_q <= exec && key_q == K_MAINT && hit && state_q[hit_idx] == TS_HALT;
            retb_q <= exec && key_q == K_HALT && hit;
            retp_q <= exec && key_q == K_HALT && trib_q == 8'h00 && !pool_busy;
            if (exec) begin
                rslot_q <= hit_idx;
                rtrib_out_q <= trib_q;
            end
        end
    end
    assign startup_req = startup_q;
    assign maint_req = maint_q;
    assign return_bufs = retb_q;
    assign return_pool = retp_q;
    assign req_slot = rslot_q;
    assign req_trib = rtrib_out_q;

    // Response mailbox; a new response wins over a software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_q <= 1'b0;
            kind_q <= R_NONE;
            code_q <= 8'h00;
            rtrib_q <= 8'h00;
            rparam_q <= 16'h0000;
        end else begin
            if (wr_acc && paddr == A_STAT && pwdata[S_RESP]) begin
                resp_q <= 1'b0;
            end
            if (exec) begin
                case (key_q)
                    K_NOP: ;
                    K_ESTAB: if (!hit && (!free || trib_q == 8'h00)) begin
                        resp_q <= 1'b1;
                        kind_q <= R_PROC;
                        code_q <= C_NO_SLOT;
                        rtrib_q <= trib_q;
                    end
                    K_DELETE: if (!hit) begin
                        resp_q <= 1'b1;
                        kind_q <= R_PROC;
                        code_q <= C_NO_SLOT;
                        rtrib_q <= trib_q;
                    end
                    K_START, K_MAINT: if (!hit || state_q[hit_idx] != TS_HALT) begin
                        resp_q <= 1'b1;
                        kind_q <= R_PROC;
                        code_q <= hit ? C_NOT_HALT : C_NO_SLOT;
                        rtrib_q <= trib_q;
                    end
                    K_HALT: if (trib_q == 8'h00) begin
                        resp_q <= 1'b1;
                        kind_q <= pool_busy ? R_PROC : R_INFO;
                        code_q <= pool_busy ? C_POOL_BUSY : C_DONE;
                        rtrib_q <= 8'h00;
                    end else if (!hit) begin
                        resp_q <= 1'b1;
                        kind_q <= R_PROC;
                        code_q <= C_NO_SLOT;
                        rtrib_q <= trib_q;
                    end
                    K_MDM_WR: ;
                    K_MDM_RD: begin
                        resp_q <= 1'b1;
                        kind_q <= R_INFO;
                        code_q <= C_DONE;
                        rtrib_q <= trib_q;
                        rparam_q <= {8'h00, modem_in};
                    end
                    default: begin
                        resp_q <= 1'b1;
                        kind_q <= R_PROC;
                        code_q <= C_BAD_KEY;
                        rtrib_q <= trib_q;
                    end
                endcase
            end else if (startup_done && valid_q[done_slot]
                && state_q[done_slot] == TS_START) begin
                resp_q <= 1'b1;
                kind_q <= R_CTRL;
                code_q <= C_RUN;
                rtrib_q <= addr_q[done_slot];
            end
        end
    end
endmodule // tcd_decoder

// ---- src/tcd_pkg.sv ----
// How it works
// - Key 02 removes the tributary and frees its status slot.
// - A deleted slot comes back only through an establish command.
// - At most twelve tributary addresses are established at once.
// - Key 03 initialises the slot and starts the link start-up sequence.
// - Finished start-up posts a run-state control response unless a command executes in the same cycle.
// - Pool and polling flag bits are honoured alongside start-up or maintenance.
// - Key 04 puts the tributary in maintenance; polling or answering stays enabled there.
// - Maintenance traffic needs both stations in the maintenance state.
// - Key 05 halts the tributary and returns all its outstanding buffers.
// - The control station stops polling a halted tributary.
// - A tributary station halted locally stops answering polls.
// - Halt keeps the slot intact so start-up can restart it.
// - Halt with address zero returns every common-pool buffer once no valid slot holds pool access.
// - Global halt while the pool is in use reports procedural error 136.
// - Key 20 copies the command parameter byte into the modem control register.
// - Key 21 returns the synchronised modem status lines in an information response.
// - Key 01 creates the status slot for the given tributary address.
// - Key 00 only applies the pool and polling flag bits and hands the command registers back.
package tcd_pkg;
    localparam int NSLOT = 12;
    localparam int SLOT_W = 4;
    localparam int KEY_W = 5;
    // Register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_TRIB = 8'h04;
    localparam logic [7:0] A_PARAM = 8'h08;
    localparam logic [7:0] A_FLAG = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_RESP = 8'h14;
    localparam logic [7:0] A_MODEM = 8'h18;
    localparam logic [7:0] A_SLOT = 8'h1C;
    // Request keys, printed octal
    localparam logic [KEY_W-1:0] K_NOP = 5'h00;
    localparam logic [KEY_W-1:0] K_ESTAB = 5'h01;
    localparam logic [KEY_W-1:0] K_DELETE = 5'h02;
    localparam logic [KEY_W-1:0] K_START = 5'h03;
    localparam logic [KEY_W-1:0] K_MAINT = 5'h04;
    localparam logic [KEY_W-1:0] K_HALT = 5'h05;
    localparam logic [KEY_W-1:0] K_MDM_WR = 5'h10;
    localparam logic [KEY_W-1:0] K_MDM_RD = 5'h11;
    // Command flag byte bit positions
    localparam int F_POOL_EN = 0;
    localparam int F_POOL_DIS = 1;
    localparam int F_POLL_UNL = 4;
    localparam int F_POLL_LAT = 5;
    // Status register bit positions
    localparam int S_RESP = 0;
    localparam int S_BUSY = 1;
    localparam int S_KIND = 2;
    localparam int S_CODE = 8;
    localparam int S_TRIB = 16;
    // Response kinds and codes
    localparam logic [1:0] R_NONE = 2'h0;
    localparam logic [1:0] R_CTRL = 2'h1;
    localparam logic [1:0] R_INFO = 2'h2;
    localparam logic [1:0] R_PROC = 2'h3;
    localparam logic [7:0] C_POOL_BUSY = 8'h88;
    localparam logic [7:0] C_NOT_HALT = 8'h89;
    localparam logic [7:0] C_NO_SLOT = 8'h8A;
    localparam logic [7:0] C_BAD_KEY = 8'h8B;
    localparam logic [7:0] C_RUN = 8'h01;
    localparam logic [7:0] C_DONE = 8'h00;
    localparam logic [7:0] MODEM_RST = 8'h00;
    typedef enum logic [1:0] {TS_HALT, TS_START, TS_RUN, TS_MAINT} tcd_trib_t;
    typedef enum logic {CS_IDLE, CS_EXEC} tcd_cmd_t;
endpackage

// ---- src/tcd_slot_match.sv ----
`timescale 1ns/1ns
module tcd_slot_match
    import tcd_pkg::*;
(
    input wire logic [tcd_pkg::NSLOT-1:0] valid,
    input wire logic [8*tcd_pkg::NSLOT-1:0] addrs,
    input wire logic [7:0] key,
    output logic hit,
    output logic [tcd_pkg::SLOT_W-1:0] hit_idx,
    output logic free,
    output logic [tcd_pkg::SLOT_W-1:0] free_idx
);
    logic [NSLOT-1:0] match;
    genvar i;
    generate
        for (i = 0; i < NSLOT; i++) begin : g_cmp
            assign match[i] = valid[i] && (addrs[8*i +: 8] == key);
        end
    endgenerate
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        free = 1'b0;
        free_idx = '0;
        // Lowest index wins in both searches
        for (int j = NSLOT - 1; j >= 0; j--) begin
            if (match[j]) begin
                hit = 1'b1;
                hit_idx = SLOT_W'(j);
            end
            if (!valid[j]) begin
                free = 1'b1;
                free_idx = SLOT_W'(j);
            end
        end
    end
endmodule // tcd_slot_match

// ---- src/tcd_sync3.sv ----
`timescale 1ns/1ns
module tcd_sync3 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, o_q;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    o_q <= 1'b0;
                end else begin
                    s1_q <= din[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Change counts only once two stages agree
                    if (s2_q == s3_q) begin
                        o_q <= s3_q;
                    end
                end
            end
            assign dout[i] = o_q;
        end
    endgenerate
endmodule // tcd_sync3

// ---- tb/tb_tributary_control_command_decoder.sv ----
`timescale 1ns/1ns
module tb_tributary_control_command_decoder;
    import tcd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, control_station = 1'b1, err_q;
    logic [7:0] paddr = 8'h00, modem_status = 8'h00, dly = 8'h01, modem_control, req_trib;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, startup_req, maint_req, return_bufs, return_pool, startup_done;
    logic [SLOT_W-1:0] req_slot, done_slot;
    logic [NSLOT-1:0] poll_enable, answer_enable, maint_enable, pool_enable;
    int fail_count = 0, samples_checked = 0, n_st, n_mt, n_bf, n_pl, n_dn;
    always #50 clk = ~clk;
    tcd_decoder uut (.*);
    tcd_link_model link (.clk(clk), .rst(rst), .dly(dly), .startup_req(startup_req),
        .req_slot(req_slot), .startup_done(startup_done), .done_slot(done_slot));
    always @(posedge clk) begin
        n_st += int'(startup_req === 1'b1);
        n_mt += int'(maint_req === 1'b1);
        n_bf += int'(return_bufs === 1'b1);
        n_pl += int'(return_pool === 1'b1);
        n_dn += int'(startup_done === 1'b1);
    end
    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setfp(input logic [7:0] f, input logic [7:0] p);
        apb(1'b1, A_FLAG, {24'h0, f});
        apb(1'b1, A_PARAM, {24'h0, p});
    endtask
    task automatic cmd(input logic [4:0] k, input logic [7:0] t);
        {n_st, n_mt, n_bf, n_pl, n_dn} = '0;
        apb(1'b1, A_STAT, 32'h1);
        apb(1'b1, A_TRIB, {24'h0, t});
        apb(1'b1, A_CMD, {27'h0, k});
        repeat (2) @(posedge clk);
    endtask
    task automatic resp(input logic [1:0] kind, input logic [7:0] code, input logic [7:0] t);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h00FFFF0F, {8'h00, t, code, 4'h0, kind, 2'b01}, "response");
    endtask
    task automatic wait_run(input logic [7:0] t);
        for (int i = 0; i < 200 && n_dn == 0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        resp(R_CTRL, C_RUN, t);
    endtask
    task automatic t_reset;
        chk(modem_control, 8'h00, "modem after reset");
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h0, "status after reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({err_q, rd}, {1'b1, 32'h0}, "unmapped read");
    endtask
    task automatic t_estab;
        for (int i = 1; i <= 12; i++) cmd(K_ESTAB, i[7:0]);
        cmd(K_ESTAB, 8'd13);
        resp(R_PROC, C_NO_SLOT, 8'd13);
        apb(1'b1, A_SLOT, 32'd11);
        apb(1'b0, A_SLOT, 32'h0);
        chk(rd, 32'h0005_810C, "slot view");
    endtask
    task automatic t_start;
        setfp(8'h01, 8'h00);
        cmd(K_START, 8'd1);
        chk(n_st, 1, "start-up pulse");
        wait_run(8'd1);
        chk({pool_enable[req_slot], poll_enable[req_slot]}, 2'b11, "pool and poll");
        cmd(K_START, 8'd1);
        resp(R_PROC, C_NOT_HALT, 8'd1);
        chk(n_st, 0, "rejected start-up");
    endtask
    task automatic t_halt;
        cmd(K_HALT, 8'd0);
        resp(R_PROC, C_POOL_BUSY, 8'd0);
        chk(n_pl, 0, "pool kept");
        cmd(K_HALT, 8'd1);
        chk({16'(n_bf), 15'h0, poll_enable[req_slot]}, 32'h0001_0000, "halt");
        setfp(8'h02, 8'h00);
        cmd(K_NOP, 8'd1);
        apb(1'b0, A_STAT, 32'h0);
        chk({rd[0], pool_enable}, '0, "nop with pool disable");
        cmd(K_HALT, 8'd0);
        chk(n_pl, 1, "pool returned");
        resp(R_INFO, C_DONE, 8'd0);
        setfp(8'h00, 8'h00);
        control_station <= 1'b0;
        dly <= 8'd20;
        repeat (5) @(posedge clk);
        cmd(K_START, 8'd1);
        wait_run(8'd1);
        chk({answer_enable[req_slot], poll_enable}, 13'h1000, "answering");
        cmd(K_HALT, 8'd1);
        chk(answer_enable[req_slot], 1'b0, "halted answers");
        control_station <= 1'b1;
    endtask
    task automatic t_maint;
        cmd(K_MAINT, 8'd2);
        chk({16'(n_mt), 15'h0, maint_enable[req_slot]}, 32'h0001_0001, "maintenance");
        cmd(K_MAINT, 8'd2);
        resp(R_PROC, C_NOT_HALT, 8'd2);
        cmd(K_HALT, 8'd2);
        chk(maint_enable[req_slot], 1'b0, "maintenance left");
        cmd(K_DELETE, 8'd2);
        cmd(K_START, 8'd2);
        resp(R_PROC, C_NO_SLOT, 8'd2);
        cmd(K_ESTAB, 8'd2);
        cmd(K_START, 8'd2);
        chk(n_st, 1, "re-established start-up");
        wait_run(8'd2);
        setfp(8'h20, 8'h01);
        cmd(K_NOP, 8'd2);
        chk(poll_enable[req_slot], 1'b0, "latched poll");
        setfp(8'h10, 8'h00);
        cmd(K_NOP, 8'd2);
        chk(poll_enable[req_slot], 1'b1, "unlatched poll");
    endtask
    task automatic t_modem;
        modem_status <= 8'h3C;
        setfp(8'h00, 8'hA5);
        cmd(K_MDM_WR, 8'd0);
        chk(modem_control, 8'hA5, "modem control");
        cmd(K_MDM_RD, 8'd0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd[3:0], {R_INFO, 2'b01}, "info response");
        apb(1'b0, A_RESP, 32'h0);
        chk(rd[15:0], 16'h003C, "modem readback");
        cmd(5'h06, 8'd0);
        resp(R_PROC, C_BAD_KEY, 8'd0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_estab();
        t_start();
        t_halt();
        t_maint();
        t_modem();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule // tb_tributary_control_command_decoder
bind tcd_decoder tcd_decoder_asserts u_chk (.*);

// ---- tb/tcd_decoder_asserts.sv ----
`timescale 1ns/1ns
module tcd_decoder_asserts
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] modem_control,
    input wire logic startup_req,
    input wire logic maint_req,
    input wire logic [tcd_pkg::SLOT_W-1:0] req_slot,
    input wire logic [7:0] req_trib,
    input wire logic return_bufs,
    input wire logic return_pool,
    input wire logic [tcd_pkg::NSLOT-1:0] poll_enable,
    input wire logic [tcd_pkg::NSLOT-1:0] answer_enable,
    input wire logic [tcd_pkg::NSLOT-1:0] maint_enable,
    input wire logic [tcd_pkg::NSLOT-1:0] pool_enable
);
    import tcd_pkg::*;
    logic [7:0] trib_q;
    logic [7:0] param_q;
    logic [KEY_W-1:0] cmd_key;
    // Unused key value marks cycles without a command write
    always_comb cmd_key = (psel && penable && pwrite && paddr == A_CMD) ? pwdata[4:0] : 5'h1F;
    always_ff @(posedge clk) begin
        if (rst) begin
            trib_q <= 8'h00;
        end else if (psel && penable && pwrite && paddr == A_TRIB) begin
            trib_q <= pwdata[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            param_q <= 8'h00;
        end else if (psel && penable && pwrite && paddr == A_PARAM) begin
            param_q <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cmd(logic [4:0] k);
        cmd_key == k;
    endsequence
    a_startup_cause: assert property (startup_req |-> $past(cmd_key, 2) == K_START)
        else $error("start-up pulse without start-up command");
    a_startup_pulse: assert property (startup_req |=> !startup_req)
        else $error("start-up pulse longer than one cycle");
    a_maint_cause: assert property (maint_req |-> $past(cmd_key, 2) == K_MAINT
        && maint_enable[req_slot])
        else $error("maintenance pulse without maintenance state");
    a_halt_return: assert property (return_bufs |-> $past(cmd_key, 2) == K_HALT
        && req_trib != 8'h00)
        else $error("buffer return without halt");
    a_halt_silent: assert property (return_bufs |-> !poll_enable[req_slot]
        && !answer_enable[req_slot])
        else $error("halted tributary still polled");
    a_pool_guard: assert property (return_pool |-> $past(cmd_key, 2) == K_HALT
        && $past(trib_q, 2) == 8'h00 && $past(pool_enable) == '0)
        else $error("pool returned while in use");
    a_global_halt: assert property ((s_cmd(K_HALT) ##0 (trib_q == 8'h00 && pool_enable == '0))
        |-> ##2 return_pool)
        else $error("global halt did not return pool");
    a_modem_write: assert property (s_cmd(K_MDM_WR) |-> ##2 modem_control == $past(param_q, 2))
        else $error("modem control not loaded");
    a_modem_hold: assert property ($changed(modem_control) |-> $past(cmd_key, 2) == K_MDM_WR)
        else $error("modem control changed without command");
    a_role_split: assert property ((poll_enable & answer_enable) == '0)
        else $error("slot both polls and answers");
endmodule // tcd_decoder_asserts

// ---- tb/tcd_link_model.sv ----
`timescale 1ns/1ns
module tcd_link_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] dly,
    input wire logic startup_req,
    input wire logic [tcd_pkg::SLOT_W-1:0] req_slot,
    output logic startup_done,
    output logic [tcd_pkg::SLOT_W-1:0] done_slot
);
    import tcd_pkg::*;
    logic [7:0] cnt_q;
    logic [SLOT_W-1:0] slot_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            slot_q <= 4'h0;
            startup_done <= 1'b0;
            done_slot <= 4'hF;
        end else begin
            startup_done <= 1'b0;
            // Idle slot scrambled so the design cannot lean on a stale index
            done_slot <= ~slot_q;
            if (startup_req) begin
                cnt_q <= dly;
                slot_q <= req_slot;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    startup_done <= 1'b1;
                    done_slot <= slot_q;
                end
            end
        end
    end
endmodule // tcd_link_model
